// [include/tc_pkg.sv]
// Constants, register map and field layout of the dual timer/counter control block.
// Assumes a classic Wishbone master with 32-bit data and byte addresses.
// Overview of operation
// - Each timer sets its own overflow flag in hardware when its count rolls over; timer 1 sets none while timer 0 is in mode 3.
// - A timer overflow flag clears itself when the processor vectors to that timer.
// - Mode selector 00 runs the timer as a 13-bit timer.
// - Mode selector 01 runs the timer as a full 16-bit timer or counter.
// - Mode selector 10 runs an 8-bit counter reloaded from the high byte on overflow.
// - Timer 0 mode 3: low byte is 8-bit timer/counter under timer 0 controls.
// - Timer 0 mode 3: high byte times machine cycles, runs on timer 1 run, sets the timer 1 flag.
// - Timer 1 in mode 3 stops and holds its count.
// - A timer counts only with run set and gate clear or its interrupt pin high.
// - In timer function the count advances once per machine cycle of 12 clocks.
// - In counter function the count advances on a sampled falling edge of its pin.
// - Mode register holds timer 1 gate at bit 7, timer 0 gate at bit 3, nibble each.
package tc_pkg;
   // Byte offsets of the registers
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_MODE = 8'h04;
   localparam logic [7:0] ADR_T0_CNT = 8'h08;
   localparam logic [7:0] ADR_T1_CNT = 8'h0C;
   localparam logic [7:0] ADR_IRQ_STS = 8'h10;
   localparam logic [7:0] ADR_IRQ_CLR = 8'h14;
   localparam logic [7:0] ADR_IRQ_EN = 8'h18;
   // timer_run_flag_control bit positions
   localparam int CTRL_T1_OVF = 7;
   localparam int CTRL_T1_RUN = 6;
   localparam int CTRL_T0_OVF = 5;
   localparam int CTRL_T0_RUN = 4;
   localparam int CTRL_X1_FLAG = 3;
   localparam int CTRL_X1_TYPE = 2;
   localparam int CTRL_X0_FLAG = 1;
   localparam int CTRL_X0_TYPE = 0;
   // timer_mode_select bit positions
   localparam int MODE_T1_GATE = 7;
   localparam int MODE_T1_CT = 6;
   localparam int MODE_T1_SEL = 4;
   localparam int MODE_T0_GATE = 3;
   localparam int MODE_T0_CT = 2;
   localparam int MODE_T0_SEL = 0;
   // Operating modes
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [3:0] PIN_IDLE = 4'hF;
   // Event and vector index: ext 0, timer 0, ext 1, timer 1
   localparam int EV_X0 = 0;
   localparam int EV_T0 = 1;
   localparam int EV_X1 = 2;
   localparam int EV_T1 = 3;
   // Pin index in the sampler
   localparam int PIN_T0 = 0;
   localparam int PIN_T1 = 1;
   localparam int PIN_X0 = 2;
   localparam int PIN_X1 = 3;
   // Clock periods per machine cycle
   localparam int CLK_PER_MC = 12;
endpackage

// [include/tc_tick_if.sv]
// Machine-cycle tick and sampled pin events shared inside the timer block.
// Assumes all users run on the same clock.
`timescale 1ns/1ps
interface tc_tick_if;
   logic tick;
   logic [3:0] fall;
   logic [3:0] level;
   modport div (output tick);
   modport samp (input tick, output fall, output level);
   modport core (input tick, input fall, input level);
endinterface

// [hdl/tc_prescale.sv]
// Divider giving a one-cycle pulse per machine cycle.
// Assumes clk is the oscillator clock.
`timescale 1ns/1ps
module tc_prescale
   import tc_pkg::*;
#(
   parameter int DIV = CLK_PER_MC
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Tick out
   tc_tick_if.div tk
);
   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } tc_div_t;
   tc_div_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == 4'(DIV - 1))
      begin
         s_d.cnt = 4'h0;
         s_d.tick = 1'b1;
      end
      else
         s_d.cnt = s_q.cnt + 4'h1;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign tk.tick = s_q.tick;
endmodule

// [hdl/tc_pin_sample.sv]
// Samples count and interrupt pins once per machine cycle and flags falling edges.
// Assumes pins are synchronous to clk.
`timescale 1ns/1ps
module tc_pin_sample
   import tc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Pins: t0 count, t1 count, irq 0, irq 1
   input wire logic [3:0] pins,
   // Sampled events
   tc_tick_if.samp tk
);
   typedef struct packed {
      logic [3:0] samp;
      logic [3:0] fall;
   } tc_samp_t;
   tc_samp_t s_q, s_d;

   always_comb
   begin
      s_d = s_q;
      s_d.fall = 4'h0;
      if (tk.tick)
      begin
         s_d.samp = pins;
         s_d.fall = s_q.samp & ~pins;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q.samp <= PIN_IDLE;
         s_q.fall <= 4'h0;
      end
      else
         s_q <= s_d;
   end

   assign tk.fall = s_q.fall;
   assign tk.level = s_q.samp;
endmodule

// [hdl/tc_timer_ctrl.sv]
// Top of the dual timer/counter control block with its Wishbone register slave.
// Assumes a classic Wishbone master and a CPU that pulses vector_ack on vectoring.
`timescale 1ns/1ps
module tc_timer_ctrl
   import tc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // External pins
   input wire logic t0_count_pin,
   input wire logic t1_count_pin,
   input wire logic ext_irq0_pin,
   input wire logic ext_irq1_pin,
   // CPU vectoring: ext 0, timer 0, ext 1, timer 1
   input wire logic [3:0] vector_ack,
   // Interrupt requests
   output logic [3:0] irq_req,
   output logic irq
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] mode;
      logic [7:0] t0_low_byte;
      logic [7:0] t0_high_byte;
      logic [7:0] t1_lo;
      logic [7:0] t1_hi;
      logic [3:0] sts;
      logic [3:0] en;
      logic ack;
      logic [31:0] dat;
   } tc_state_t;
   tc_state_t s_q, s_d;

   tc_tick_if tk ();

   tc_prescale #(.DIV(CLK_PER_MC)) u_div (
      .clk(clk),
      .arst_n(arst_n),
      .tk(tk)
   );

   tc_pin_sample u_samp (
      .clk(clk),
      .arst_n(arst_n),
      .pins({ext_irq1_pin, ext_irq0_pin, t1_count_pin, t0_count_pin}),
      .tk(tk)
   );

   // One count step: returns {overflow, high, low}
   function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] hi,
                                        input logic [7:0] lo);
      logic [13:0] v13;
      logic [16:0] v16;
      logic [8:0] v8;
      v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      v16 = {1'b0, hi, lo} + 17'h00001;
      v8 = {1'b0, lo} + 9'h001;
      unique case (m)
         MODE_13BIT: step = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
         MODE_16BIT: step = v16;
         MODE_RELOAD: step = {v8[8], hi, v8[8] ? hi : v8[7:0]};
         MODE_SPLIT: step = {1'b0, hi, lo};
      endcase
   endfunction

   // Byte-lane merge of a write into an 8-bit field
   function automatic logic [7:0] lane(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] sel, input int b);
      lane = sel[b] ? d[8*b +: 8] : old;
   endfunction

   logic hit, wr;
   logic [1:0] m0, m1;
   logic run0, run1, inc0, inc1, inc0h;
   logic set_t0, set_t1, set_x0, set_x1;
   logic [16:0] r0, r1;
   logic [8:0] lo8, hi8;
   logic [7:0] c;

   always_comb
   begin
      s_d = s_q;
      hit = wb_cyc_i & wb_stb_i;
      wr = hit & wb_we_i & s_q.ack;
      s_d.ack = hit & ~s_q.ack;
      m0 = s_q.mode[MODE_T0_SEL +: 2];
      m1 = s_q.mode[MODE_T1_SEL +: 2];
      // Counted input gating
      run0 = s_q.ctrl[CTRL_T0_RUN] & (~s_q.mode[MODE_T0_GATE] | ext_irq0_pin);
      run1 = s_q.ctrl[CTRL_T1_RUN] & (~s_q.mode[MODE_T1_GATE] | ext_irq1_pin);
      inc0 = run0 & (s_q.mode[MODE_T0_CT] ? tk.fall[PIN_T0] : tk.tick);
      inc1 = run1 & (s_q.mode[MODE_T1_CT] ? tk.fall[PIN_T1] : tk.tick);
      inc0h = s_q.ctrl[CTRL_T1_RUN] & tk.tick;
      set_t0 = 1'b0;
      set_t1 = 1'b0;
      r0 = step(m0, s_q.t0_high_byte, s_q.t0_low_byte);
      r1 = step(m1, s_q.t1_hi, s_q.t1_lo);
      lo8 = {1'b0, s_q.t0_low_byte} + 9'h001;
      hi8 = {1'b0, s_q.t0_high_byte} + 9'h001;
      // Timer 0
      if (m0 == MODE_SPLIT)
      begin
         if (inc0)
         begin
            s_d.t0_low_byte = lo8[7:0];
            set_t0 = lo8[8];
         end
         if (inc0h)
         begin
            s_d.t0_high_byte = hi8[7:0];
            set_t1 = hi8[8];
         end
      end
      else if (inc0)
      begin
         {set_t0, s_d.t0_high_byte, s_d.t0_low_byte} = r0;
      end
      // Timer 1 keeps counting while timer 0 borrows its flag, but raises none
      if (inc1 && m1 != MODE_SPLIT)
      begin
         s_d.t1_hi = r1[15:8];
         s_d.t1_lo = r1[7:0];
         if (m0 != MODE_SPLIT)
            set_t1 = r1[16];
      end
      // External interrupt events
      set_x0 = s_q.ctrl[CTRL_X0_TYPE] ? tk.fall[PIN_X0] : ~tk.level[PIN_X0];
      set_x1 = s_q.ctrl[CTRL_X1_TYPE] ? tk.fall[PIN_X1] : ~tk.level[PIN_X1];
      // Control register: software write, vector clear, then hardware set wins
      c = s_q.ctrl;
      if (wr && wb_adr_i == ADR_CTRL)
         c = lane(c, wb_dat_i, wb_sel_i, 0);
      if (vector_ack[EV_T0])
         c[CTRL_T0_OVF] = 1'b0;
      if (vector_ack[EV_T1])
         c[CTRL_T1_OVF] = 1'b0;
      if (s_q.ctrl[CTRL_X0_TYPE])
      begin
         if (vector_ack[EV_X0])
            c[CTRL_X0_FLAG] = 1'b0;
      end
      else
         c[CTRL_X0_FLAG] = 1'b0;
      if (s_q.ctrl[CTRL_X1_TYPE])
      begin
         if (vector_ack[EV_X1])
            c[CTRL_X1_FLAG] = 1'b0;
      end
      else
         c[CTRL_X1_FLAG] = 1'b0;
      c[CTRL_T0_OVF] = c[CTRL_T0_OVF] | set_t0;
      c[CTRL_T1_OVF] = c[CTRL_T1_OVF] | set_t1;
      c[CTRL_X0_FLAG] = c[CTRL_X0_FLAG] | set_x0;
      c[CTRL_X1_FLAG] = c[CTRL_X1_FLAG] | set_x1;
      s_d.ctrl = c;
      // Other registers; a count write overrides the step in that cycle
      if (wr)
      begin
         unique case (wb_adr_i)
            ADR_MODE: s_d.mode = lane(s_q.mode, wb_dat_i, wb_sel_i, 0);
            ADR_T0_CNT:
            begin
               s_d.t0_low_byte = lane(s_d.t0_low_byte, wb_dat_i, wb_sel_i, 0);
               s_d.t0_high_byte = lane(s_d.t0_high_byte, wb_dat_i, wb_sel_i, 1);
            end
            ADR_T1_CNT:
            begin
               s_d.t1_lo = lane(s_d.t1_lo, wb_dat_i, wb_sel_i, 0);
               s_d.t1_hi = lane(s_d.t1_hi, wb_dat_i, wb_sel_i, 1);
            end
            ADR_IRQ_EN: s_d.en = wb_sel_i[0] ? wb_dat_i[3:0] : s_q.en;
            ADR_IRQ_CLR: s_d.sts = wb_sel_i[0] ? s_q.sts & ~wb_dat_i[3:0] : s_q.sts;
            default: s_d.mode = s_q.mode;
         endcase
      end
      // Sticky status, set wins over clear
      s_d.sts[EV_X0] = s_d.sts[EV_X0] | set_x0;
      s_d.sts[EV_T0] = s_d.sts[EV_T0] | set_t0;
      s_d.sts[EV_X1] = s_d.sts[EV_X1] | set_x1;
      s_d.sts[EV_T1] = s_d.sts[EV_T1] | set_t1;
      // Read data, captured as the answer is raised
      if (hit && !s_q.ack)
      begin
         unique case (wb_adr_i)
            ADR_CTRL: s_d.dat = {24'h000000, s_q.ctrl};
            ADR_MODE: s_d.dat = {24'h000000, s_q.mode};
            ADR_T0_CNT: s_d.dat = {16'h0000, s_q.t0_high_byte, s_q.t0_low_byte};
            ADR_T1_CNT: s_d.dat = {16'h0000, s_q.t1_hi, s_q.t1_lo};
            ADR_IRQ_STS: s_d.dat = {28'h0000000, s_q.sts};
            ADR_IRQ_EN: s_d.dat = {28'h0000000, s_q.en};
            default: s_d.dat = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RESET;
         s_q.mode <= MODE_RESET;
      end
      else
         s_q <= s_d;
   end

   assign wb_ack_o = s_q.ack;
   assign wb_dat_o = s_q.dat;
   assign irq_req = {s_q.ctrl[CTRL_T1_OVF], s_q.ctrl[CTRL_X1_FLAG],
                     s_q.ctrl[CTRL_T0_OVF], s_q.ctrl[CTRL_X0_FLAG]};
   assign irq = |(s_q.sts & s_q.en);
endmodule

// [test/tc_pin_model.sv]
// Model of the external count and interrupt pins of the timer block.
// Assumes the bench sets want; pins idle high like pulled-up lines.
`timescale 1ns/1ps
module tc_pin_model
   import tc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Levels asked by the bench
   input wire logic [3:0] want,
   // Pins
   output logic [3:0] pins
);
   // Levels move only at a clock edge and follow want one clock later
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         pins <= PIN_IDLE;
      else
         pins <= want;
   end
endmodule

// [test/tc_timer_ctrl_chk.sv]
// Assertions on the ports of the timer control block.
// Assumes one clock domain; bound from the bench top.
`timescale 1ns/1ps
module tc_timer_ctrl_chk
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Bus
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Pins and vectoring
   input wire logic ext_irq1_pin,
   input wire logic [3:0] vector_ack,
   input wire logic [3:0] irq_req
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("ack longer than one cycle");
   property p_ack_resp;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_resp: assert property (p_ack_resp)
      else $error("ack missing one cycle after request");
   property p_ack_idle;
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
   endproperty
   a_ack_idle: assert property (p_ack_idle)
      else $error("ack without request");
   property p_dat_hold;
      !wb_ack_o |-> $stable(wb_dat_o);
   endproperty
   a_dat_hold: assert property (p_dat_hold)
      else $error("read data moved outside an access");
   property p_t0_fall;
      $fell(irq_req[1]) |-> $past(vector_ack[1] || (wb_ack_o && wb_we_i));
   endproperty
   a_t0_fall: assert property (p_t0_fall)
      else $error("timer 0 flag cleared without cause");
   property p_t1_fall;
      $fell(irq_req[3]) |-> $past(vector_ack[3] || (wb_ack_o && wb_we_i));
   endproperty
   a_t1_fall: assert property (p_t1_fall)
      else $error("timer 1 flag cleared without cause");
   property p_t0_vec;
      vector_ack[1] |=> !irq_req[1];
   endproperty
   a_t0_vec: assert property (p_t0_vec)
      else $error("timer 0 flag kept after vectoring");
   property p_x1_rise;
      $rose(irq_req[2]) |-> !$past(ext_irq1_pin) || !$past(ext_irq1_pin, 2)
         || $past(wb_ack_o && wb_we_i);
   endproperty
   a_x1_rise: assert property (p_x1_rise)
      else $error("ext 1 flag set while pin high");
endmodule

// [test/tc_timer_ctrl_bench.sv]
// Self-checking bench for the timer control block.
// Assumes checker and pin model are compiled before it.
`timescale 1ns/1ps
module tc_timer_ctrl_bench
   import tc_pkg::*;
;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hF;
   logic [3:0] lanes = 4'hF;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic ack;
   logic [3:0] vec = 4'h0;
   logic [3:0] want = 4'hF;
   logic [3:0] pins;
   logic [3:0] req;
   logic irq;
   int miscompares = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   tc_pin_model pin_u (.clk(clk), .arst_n(arst_n), .want(want), .pins(pins));
   tc_timer_ctrl dut_u (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .t0_count_pin(pins[PIN_T0]), .t1_count_pin(pins[PIN_T1]),
      .ext_irq0_pin(pins[PIN_X0]), .ext_irq1_pin(pins[PIN_X1]), .vector_ack(vec),
      .irq_req(req), .irq(irq));
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= lanes;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 50)
      begin
         n++;
         @(posedge clk);
      end
      if (n >= 50)
      begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, ack, 1'b1);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask
   task automatic wreq(input int b);
      int n;
      n = 0;
      while (req[b] !== 1'b1 && n < 400)
      begin
         n++;
         @(posedge clk);
      end
      chk({31'h0, req[b]}, 32'h1);
   endtask
   task automatic vect(input logic [3:0] v);
      vec <= v;
      @(posedge clk);
      vec <= 4'h0;
      @(posedge clk);
   endtask
   task automatic idle;
      wr(ADR_CTRL, 32'h0);
      wr(ADR_IRQ_CLR, 32'hF);
   endtask
   task automatic t_regs;
      rdc(ADR_CTRL, {24'h0, CTRL_RESET});
      rdc(ADR_MODE, {24'h0, MODE_RESET});
      wr(ADR_MODE, 32'h88);
      rdc(ADR_MODE, 32'h88);
      rdc(8'hFC, 32'h0);
      wr(ADR_IRQ_EN, 32'hF);
      // Only the high count byte is enabled
      lanes = 4'h2;
      wr(ADR_T1_CNT, 32'h0000BEEF);
      lanes = 4'hF;
      rdc(ADR_T1_CNT, 32'h0000BE00);
   endtask
   task automatic t_mode1;
      wr(ADR_MODE, 32'h01);
      wr(ADR_T0_CNT, 32'hFFFE);
      wr(ADR_CTRL, 32'h10);
      wreq(EV_T0);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      repeat (53) @(posedge clk);
      rdc(ADR_T0_CNT, 32'h4);
      vect(4'h2);
      chk({28'h0, req}, 32'h0);
      wr(ADR_IRQ_CLR, 32'h2);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      idle;
   endtask
   task automatic t_mode0;
      wr(ADR_MODE, 32'h00);
      wr(ADR_T0_CNT, 32'hFFFF);
      wr(ADR_CTRL, 32'h10);
      wreq(EV_T0);
      rdc(ADR_T0_CNT, 32'h00E0);
      idle;
   endtask
   task automatic t_mode2;
      wr(ADR_MODE, 32'h20);
      wr(ADR_T1_CNT, 32'hA5FF);
      wr(ADR_CTRL, 32'h40);
      wreq(EV_T1);
      rdc(ADR_T1_CNT, 32'hA5A5);
      idle;
   endtask
   task automatic t_split;
      wr(ADR_MODE, 32'h33);
      wr(ADR_T0_CNT, 32'hFF00);
      wr(ADR_T1_CNT, 32'h1234);
      wr(ADR_CTRL, 32'h40);
      wreq(EV_T1);
      rdc(ADR_T0_CNT, 32'h0000);
      rdc(ADR_T1_CNT, 32'h1234);
      // Stop timer 1 run first so the borrowed high byte stays at zero
      wr(ADR_CTRL, 32'h10);
      wr(ADR_T0_CNT, 32'h00FF);
      wreq(EV_T0);
      rdc(ADR_T0_CNT, 32'h0000);
      idle;
   endtask
   task automatic t_gate;
      logic [31:0] q;
      wr(ADR_MODE, 32'h09);
      wr(ADR_T0_CNT, 32'h0);
      want[PIN_X0] <= 1'b0;
      wr(ADR_CTRL, 32'h10);
      repeat (48) @(posedge clk);
      rdc(ADR_T0_CNT, 32'h0);
      chk({31'h0, req[EV_X0]}, 32'h1);
      want[PIN_X0] <= 1'b1;
      repeat (48) @(posedge clk);
      chk({31'h0, req[EV_X0]}, 32'h0);
      bus(1'b0, ADR_T0_CNT, 32'h0, q);
      chk({31'h0, q[15:0] == 16'h0}, 32'h0);
      idle;
   endtask
   task automatic t_count;
      wr(ADR_MODE, 32'h55);
      wr(ADR_T0_CNT, 32'h0);
      wr(ADR_T1_CNT, 32'h0);
      wr(ADR_CTRL, 32'h50);
      repeat (3)
      begin
         want <= 4'hC;
         repeat (24) @(posedge clk);
         want <= 4'hF;
         repeat (24) @(posedge clk);
      end
      rdc(ADR_T0_CNT, 32'h3);
      rdc(ADR_T1_CNT, 32'h3);
      idle;
   endtask
   task automatic t_edge;
      wr(ADR_IRQ_EN, 32'h0);
      wr(ADR_CTRL, 32'h04);
      want[PIN_X1] <= 1'b0;
      repeat (24) @(posedge clk);
      want[PIN_X1] <= 1'b1;
      repeat (36) @(posedge clk);
      chk({31'h0, req[EV_X1]}, 32'h1);
      chk({31'h0, irq}, 32'h0);
      rdc(ADR_IRQ_STS, 32'h4);
      wr(ADR_IRQ_EN, 32'h4);
      @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      vect(4'h4);
      chk({31'h0, req[EV_X1]}, 32'h0);
      rdc(ADR_IRQ_CLR, 32'h0);
      wr(ADR_IRQ_CLR, 32'h4);
      @(posedge clk);
      chk({31'h0, irq}, 32'h0);
   endtask
   initial
   begin
      #200000;
      miscompares++;
      stop_test;
   end
   initial
   begin
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_regs;
      t_mode1;
      t_mode0;
      t_mode2;
      t_split;
      t_gate;
      t_count;
      t_edge;
      stop_test;
   end
endmodule
bind tc_timer_ctrl tc_timer_ctrl_chk chk_u (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .ext_irq1_pin(ext_irq1_pin), .vector_ack(vector_ack), .irq_req(irq_req));
